// File: cio_pkg.sv
/*
 * shared constants, register map and carrier types of the control-line
 * decoder; assumes a 50 MHz system clock and a 32-bit classic wishbone bus.
 */
// What this block does
// - backlight forced on while force input asserted
// - touch events ignored while lockout asserted
// - restart input causes full unit restart
// - work lines act only with external_source_option
// - work number equals binary lines plus one
// - zone input steps through enabled zones only
// - clear input clears results, judgment outputs, starts continuous
// - judgment mask holds all judgment outputs inactive
// - measure input acts only with external_signal_option
// - edge control: each rising edge toggles measuring
// - level control: assert starts, deassert stops
// - displacement zero captures present count as reference
// - load zero input requests digital zero
// - drive error, complete, trigger, judgment outputs
// - completion active when measurement finished
// - two-phase: count both edges, direction from phase
// - single-phase: count each phase A activation
package cio_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50; // system clock rate
    localparam int DEB_TIME_US = 1000; // contact debounce time
    localparam int WORK_TIME_US = 5000; // work lines settle time
    localparam int DEB_CYC = DEB_TIME_US * CLK_MHZ;
    localparam int WORK_CYC = WORK_TIME_US * CLK_MHZ;
    localparam int DEB_W = 17; // debounce counter width
    localparam int WORK_W = 20; // work settle counter width
    // ------------------------------------------------------------
    // widths and register map (byte addresses)
    // ------------------------------------------------------------
    localparam int N_IN = 13; // debounced control lines
    localparam int CNT_W = 16; // displacement counter width
    localparam int N_ZONE = 5;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_ZONE_EN = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_SELECT = 8'h0C;
    localparam logic [7:0] ADR_EVENTS = 8'h10;
    localparam logic [7:0] ADR_JUDGE = 8'h14;
    localparam logic [7:0] ADR_DISP = 8'h18;
    localparam logic [7:0] ADR_DZERO = 8'h1C;
    localparam logic [7:0] ADR_CMD = 8'h20;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [4:0] ZONE_EN_RST = 5'h1F;
    // control register fields
    localparam int C_WORK_EXT = 0;
    localparam int C_ZONE_EXT = 1;
    localparam int C_START_EXT = 2;
    localparam int C_STOP_EXT = 3;
    localparam int C_EDGE = 4;
    localparam int C_TWO_PH = 5;
    localparam int C_BL_ON = 6;
    // debounced input bit positions
    localparam int I_BL = 0, I_TOUCH = 1, I_RESTART = 2, I_W1 = 3;
    localparam int I_ZONE = 7, I_CLEAR = 8, I_MASK = 9, I_MEAS = 10;
    localparam int I_DZERO = 11, I_LZERO = 12;
    localparam int EV_W = 7; // sticky event count
    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef enum logic {MS_IDLE, MS_RUN} cio_meas_e;
    typedef struct packed {
        logic [2:0] band; // load hi/ok/lo band judgment
        logic [2:0] disp; // displacement hi/ok/lo
        logic [4:0] load; // upper_upper_limit..lower_lower_limit
    } cio_judge_s;
    typedef struct packed {
        logic unit_err;
        logic cell_err;
        logic complete;
        logic [1:0] trig;
    } cio_stat_s;
    localparam int JUDGE_W = $bits(cio_judge_s);
endpackage : cio_pkg

// File: cio_debounce.sv
/*
 * two-stage synchroniser and per-line debounce filter; assumes the lines
 * arrive asynchronously and bounce for less than the debounce time.
 */
`timescale 1ns/1ps
module cio_debounce
    import cio_pkg::*;
#(
    parameter int W = 1,
    parameter logic [DEB_W-1:0] CYC = DEB_W'(DEB_CYC)
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // lines
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] clean_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_line
            logic s1_reg; // first stage, read only by s2
            logic s2_reg;
            logic [DEB_W-1:0] cnt_reg;
            // ------------------------------------------------------------
            // synchroniser
            // ------------------------------------------------------------
            always_ff @(posedge clk_i)
            begin
                s1_reg <= rst_i ? 1'b0 : raw_i[g];
                s2_reg <= rst_i ? 1'b0 : s1_reg;
            end
            // filter: output follows only after CYC steady cycles
            always_ff @(posedge clk_i)
            begin
                if (rst_i || s2_reg == clean_o[g])
                    cnt_reg <= '0;
                else
                    cnt_reg <= cnt_reg + 1'b1;
            end
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    clean_o[g] <= 1'b0;
                else if (cnt_reg >= CYC - 1'b1)
                    clean_o[g] <= s2_reg;
            end
        end
    endgenerate
endmodule : cio_debounce

// File: cio_quad.sv
/*
 * displacement pulse counter for phase A/B lines; assumes the lines are
 * already at logic level, asynchronous, and slower than a quarter clock.
 */
`timescale 1ns/1ps
module cio_quad
    import cio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // phase lines and mode
    input wire logic pha_i,
    input wire logic phb_i,
    input wire logic two_phase_i,
    output logic [CNT_W-1:0] count_o
);
    logic [1:0] a_reg, b_reg; // [0] first stage only
    logic a_old_reg, b_old_reg;
    logic a_chg, b_chg, dir_up;
    // ------------------------------------------------------------
    // synchronise, keep previous sample
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_reg <= '0;
            b_reg <= '0;
            a_old_reg <= 1'b0;
            b_old_reg <= 1'b0;
        end
        else
        begin
            a_reg <= {a_reg[0], pha_i};
            b_reg <= {b_reg[0], phb_i};
            a_old_reg <= a_reg[1];
            b_old_reg <= b_reg[1];
        end
    end
    assign a_chg = a_reg[1] ^ a_old_reg;
    assign b_chg = b_reg[1] ^ b_old_reg;
    // up when a leads b
    assign dir_up = a_chg ? (a_reg[1] != b_reg[1]) : (a_reg[1] == b_reg[1]);
    // counter; in two-phase mode a simultaneous a/b change is a lost step, not counted
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_o <= '0;
        else if (two_phase_i)
        begin
            if (a_chg ^ b_chg)
                count_o <= dir_up ? count_o + 1'b1 : count_o - 1'b1;
        end
        else if (a_chg && a_reg[1])
            count_o <= count_o + 1'b1;
    end
endmodule : cio_quad

// File: cio_control_io_decoder.sv
/*
 * control-line decoder top: turns isolated control inputs into unit
 * actions and drives the status and judgment lines. assumes the input
 * pins read 1 while asserted (either wiring variant) and a classic
 * wishbone master on the same clock.
 */
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module cio_control_io_decoder
    import cio_pkg::*;
#(
    parameter logic [DEB_W-1:0] DEB_CYCLES = DEB_W'(DEB_CYC),
    parameter logic [WORK_W-1:0] WORK_CYCLES = WORK_W'(WORK_CYC)
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // control input pins, asynchronous
    input wire logic [N_IN-1:0] ctl_pins_i,
    input wire logic pha_i,
    input wire logic phb_i,
    // touch event path
    input wire logic touch_valid_i,
    output logic touch_valid_o,
    // unit actions
    output logic backlight_o,
    output logic touch_locked_o,
    output logic restart_o,
    output logic [4:0] work_num_o,
    output logic [2:0] zone_o,
    output logic measuring_o,
    output logic continuous_o,
    output logic disp_zero_o,
    output logic load_zero_o,
    // output lines
    output cio_stat_s stat_o,
    output cio_judge_s judge_o
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [N_IN-1:0] in_db; // debounced lines
    logic [N_IN-1:0] in_old_reg; // previous debounced lines
    logic [N_IN-1:0] rise, fall;
    logic [CNT_W-1:0] count; // raw displacement count
    logic [CNT_W-1:0] dzero_reg; // zero reference
    logic [6:0] ctrl_reg;
    logic [4:0] zone_en_reg;
    logic [EV_W-1:0] ev_reg, ev_set; // sticky events
    cio_judge_s res_reg; // stored judgment results
    cio_stat_s stat_reg;
    cio_meas_e ms_reg, ms_next;
    logic [3:0] wsel_old_reg;
    logic [WORK_W-1:0] wcnt_reg;
    logic [3:0] wsel;
    logic bus_req, wr, rd;
    logic [31:0] wmask;
    logic sw_start, sw_stop, ext_start, ext_stop;
    logic done_reg; // measurement finished flag

    // byte-lane mask, used by every writable register but stat_reg, which is gated by sel_i[1]
    function automatic logic [31:0] lanes(input logic [3:0] s);
        lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lanes

    // next enabled zone after z, or z itself when none enabled
    function automatic logic [2:0] next_zone(input logic [2:0] z,
                                             input logic [4:0] en);
        logic [2:0] c;
        c = z;
        next_zone = z;
        for (int k = 0; k < N_ZONE; k++)
        begin
            c = (c == 3'(N_ZONE - 1)) ? 3'h0 : c + 3'h1;
            if (en[c] && next_zone == z)
                next_zone = c;
        end
    endfunction : next_zone

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    cio_debounce #(
        .W(N_IN),
        .CYC(DEB_CYCLES)
    ) u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(ctl_pins_i),
        .clean_o(in_db)
    );

    cio_quad u_quad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pha_i(pha_i),
        .phb_i(phb_i),
        .two_phase_i(ctrl_reg[C_TWO_PH]),
        .count_o(count)
    );

    // edge detection on the clean lines only
    always_ff @(posedge clk_i)
    begin
        in_old_reg <= rst_i ? '0 : in_db;
    end
    assign rise = in_db & ~in_old_reg;
    assign fall = ~in_db & in_old_reg;
    assign wsel = in_db[I_W1+3:I_W1];

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign wr = cyc_i & stb_i & we_i & ack_o; // lands on the ack edge
    assign rd = bus_req & ~we_i;
    assign wmask = lanes(sel_i);

    // one wait state: ack one cycle after the strobe, dropped next
    always_ff @(posedge clk_i)
    begin
        ack_o <= rst_i ? 1'b0 : bus_req;
    end

    // read mux; unmapped addresses read as zero but still ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (rd)
        begin
            unique case (adr_i)
                ADR_CTRL: dat_o <= 32'(ctrl_reg);
                ADR_ZONE_EN: dat_o <= 32'(zone_en_reg);
                ADR_STATUS: dat_o <= 32'({continuous_o, done_reg,
                                          measuring_o, in_db});
                ADR_SELECT: dat_o <= 32'({zone_o, 3'h0, work_num_o});
                ADR_EVENTS: dat_o <= 32'(ev_reg);
                ADR_JUDGE: dat_o <= 32'({stat_reg, res_reg});
                ADR_DISP: dat_o <= 32'(count - dzero_reg);
                ADR_DZERO: dat_o <= 32'(dzero_reg);
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // control register: sources, trigger style, counter mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_reg <= CTRL_RST;
        else if (wr && adr_i == ADR_CTRL)
            ctrl_reg <= (ctrl_reg & ~wmask[6:0]) | (dat_i[6:0] & wmask[6:0]);
    end

    // zone judgment enables
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            zone_en_reg <= ZONE_EN_RST;
        else if (wr && adr_i == ADR_ZONE_EN)
            zone_en_reg <= (zone_en_reg & ~wmask[4:0])
                         | (dat_i[4:0] & wmask[4:0]);
    end

    // software start/stop strobes
    assign sw_start = wr && adr_i == ADR_CMD && sel_i[0] && dat_i[0];
    assign sw_stop = wr && adr_i == ADR_CMD && sel_i[0] && dat_i[1];

    // ------------------------------------------------------------
    // sticky events: restart, clear, zeros, start, stop, work change
    // ------------------------------------------------------------
    assign ev_set = {wcnt_reg == WORK_CYCLES - 1'b1,
                     ms_reg == MS_RUN && ms_next == MS_IDLE,
                     ms_reg == MS_IDLE && ms_next == MS_RUN,
                     rise[I_LZERO], rise[I_DZERO], rise[I_CLEAR],
                     rise[I_RESTART]};
    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ev_reg <= '0;
        else if (wr && adr_i == ADR_EVENTS)
            ev_reg <= (ev_reg & ~(dat_i[EV_W-1:0] & wmask[EV_W-1:0]))
                    | ev_set;
        else
            ev_reg <= ev_reg | ev_set;
    end

    // ------------------------------------------------------------
    // simple actions
    // ------------------------------------------------------------
    // registered so glitch-free toward the panel and touch logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            backlight_o <= 1'b0;
            touch_locked_o <= 1'b0;
            touch_valid_o <= 1'b0;
            restart_o <= 1'b0;
            disp_zero_o <= 1'b0;
            load_zero_o <= 1'b0;
        end
        else
        begin
            backlight_o <= in_db[I_BL] | ctrl_reg[C_BL_ON];
            touch_locked_o <= in_db[I_TOUCH];
            touch_valid_o <= touch_valid_i & ~in_db[I_TOUCH];
            restart_o <= rise[I_RESTART];
            disp_zero_o <= rise[I_DZERO];
            load_zero_o <= rise[I_LZERO];
        end
    end
    // restart during a storage write may lose data; the controller
    // must avoid it, nothing here delays the pulse.

    // zero reference taken from the live count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dzero_reg <= '0;
        else if (rise[I_DZERO])
            dzero_reg <= count;
    end

    // ------------------------------------------------------------
    // work number: apply only after all four lines settle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wsel_old_reg <= '0;
            wcnt_reg <= '0;
        end
        else
        begin
            wsel_old_reg <= wsel;
            if (wsel != wsel_old_reg)
                wcnt_reg <= '0;
            else if (wcnt_reg != WORK_CYCLES)
                wcnt_reg <= wcnt_reg + 1'b1;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            work_num_o <= 5'h01;
        else if (ctrl_reg[C_WORK_EXT]
                 && wcnt_reg == WORK_CYCLES - 1'b1)
            work_num_o <= {1'b0, wsel} + 5'h01;
    end

    // zone stepping on each assertion of the zone line
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            zone_o <= '0;
        else if (ctrl_reg[C_ZONE_EXT] && rise[I_ZONE])
            zone_o <= next_zone(zone_o, zone_en_reg);
    end

    // ------------------------------------------------------------
    // measurement start/stop
    // ------------------------------------------------------------
    always_comb
    begin
        ext_start = 1'b0;
        ext_stop = 1'b0;
        if (ctrl_reg[C_EDGE])
        begin
            // edge: each rise flips run state
            ext_start = rise[I_MEAS] && ms_reg == MS_IDLE;
            ext_stop = rise[I_MEAS] && ms_reg == MS_RUN;
        end
        else
        begin
            ext_start = rise[I_MEAS];
            ext_stop = fall[I_MEAS];
        end
        ext_start = ext_start & ctrl_reg[C_START_EXT];
        ext_stop = ext_stop & ctrl_reg[C_STOP_EXT];
    end

    always_comb
    begin
        ms_next = ms_reg;
        unique case (ms_reg)
            MS_IDLE: if (ext_start || sw_start) ms_next = MS_RUN;
            MS_RUN: if (ext_stop || sw_stop) ms_next = MS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        ms_reg <= rst_i ? MS_IDLE : ms_next;
    end
    assign measuring_o = (ms_reg == MS_RUN);

    // finished flag: set on stop, cleared on the next start
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ms_reg == MS_IDLE && ms_next == MS_RUN))
            done_reg <= 1'b0;
        else if (ms_reg == MS_RUN && ms_next == MS_IDLE)
            done_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // judgment results and output lines
    // ------------------------------------------------------------
    // clear line beats a software write landing in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i || rise[I_CLEAR])
            res_reg <= '0;
        else if (wr && adr_i == ADR_JUDGE)
            res_reg <= (res_reg & ~wmask[JUDGE_W-1:0])
                     | (dat_i[JUDGE_W-1:0] & wmask[JUDGE_W-1:0]);
    end

    // continuous judgment runs from a clear until a measurement starts
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ms_reg == MS_IDLE && ms_next == MS_RUN))
            continuous_o <= 1'b0;
        else if (rise[I_CLEAR])
            continuous_o <= 1'b1;
    end

    // error and trigger levels come from software
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat_reg <= '0;
        else if (wr && adr_i == ADR_JUDGE && sel_i[1])
            stat_reg <= dat_i[JUDGE_W+4:JUDGE_W];
    end

    // line drivers, all from flip-flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            judge_o <= '0;
            stat_o <= '0;
        end
        else
        begin
            judge_o <= in_db[I_MASK] ? '0 : res_reg;
            stat_o.unit_err <= stat_reg.unit_err;
            stat_o.cell_err <= stat_reg.cell_err;
            stat_o.complete <= done_reg;
            stat_o.trig <= stat_reg.trig;
        end
    end

    // both wiring variants look alike here: the pin reads 1 while
    // shorted to return_terminal or fed with supply.
endmodule : cio_control_io_decoder

// File: cio_monitor.sv
/*
 * port checker for the control-line decoder, bound to its top;
 * assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module cio_monitor
    import cio_pkg::*;
#(
    parameter logic [DEB_W-1:0] DEB_CYCLES = DEB_W'(DEB_CYC),
    parameter logic [WORK_W-1:0] WORK_CYCLES = WORK_W'(WORK_CYC)
)(
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // pins and actions
    input wire logic [N_IN-1:0] ctl_pins_i,
    input wire logic touch_valid_i,
    input wire logic touch_valid_o,
    input wire logic touch_locked_o,
    input wire logic restart_o,
    input wire logic [4:0] work_num_o,
    input wire logic [2:0] zone_o,
    input wire logic measuring_o,
    input wire logic continuous_o,
    input wire cio_stat_s stat_o,
    input wire cio_judge_s judge_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answers after exactly one wait, for one cycle
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered after one wait");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    // locked touch never passes, unlocked always does
    chk_touch_off: assert property (touch_locked_o |-> !touch_valid_o)
        else $error("touch event passed while locked");
    chk_touch_pass: assert property
        (!touch_locked_o && $past(touch_valid_i) |-> touch_valid_o)
        else $error("touch event lost while unlocked");
    // restart pulse only after a held pin, one cycle wide
    chk_restart_cause: assert property
        (restart_o |-> $past(ctl_pins_i[I_RESTART], 4) && !$past(restart_o))
        else $error("restart pulse without a held pin");
    chk_work_span: assert property (work_num_o inside {[5'h01:5'h10]})
        else $error("work number outside one to sixteen");
    chk_zone_range: assert property (zone_o < 3'(N_ZONE))
        else $error("zone index out of range");
    chk_clear_judge: assert property
        ($rose(continuous_o) |-> ##[0:1] judge_o == '0)
        else $error("judgment lines not cleared");
    chk_complete_stop: assert property
        ($rose(stat_o.complete) |-> !measuring_o)
        else $error("complete raised while measuring");
endmodule : cio_monitor

bind cio_control_io_decoder cio_monitor #(.DEB_CYCLES(DEB_CYCLES),
    .WORK_CYCLES(WORK_CYCLES)) cio_monitor_inst (.clk_i, .rst_i, .cyc_i,
    .stb_i, .ack_o, .ctl_pins_i, .touch_valid_i, .touch_valid_o,
    .touch_locked_o, .restart_o, .work_num_o, .zone_o, .measuring_o,
    .continuous_o, .stat_o, .judge_o);

// File: cio_plc_model.sv
/*
 * controller model driving the control pins, one bounce per change;
 * assumes a pin reads 1 while asserted in either wiring variant.
 */
`timescale 1ns/1ps
module cio_plc_model
    import cio_pkg::*;
(
    // clock
    input wire logic clk_i,
    // wanted levels and pins
    input wire logic [N_IN-1:0] want_i,
    output logic [N_IN-1:0] pins_o
);
    logic [N_IN-1:0] d1_reg = '0; // levels one and two cycles back
    logic [N_IN-1:0] d2_reg = '0;
    initial pins_o = '0;
    // contacts bounce back once, shorter than the filter time
    always @(posedge clk_i)
    begin
        d1_reg <= want_i;
        d2_reg <= d1_reg;
        pins_o <= (d1_reg != d2_reg) ? d2_reg : want_i;
    end
endmodule : cio_plc_model

// File: tb_control_io_decoder.sv
/*
 * self-checking bench of the control-line decoder; assumes short
 * debounce and settle counts, bus master and controller model here.
 */
`timescale 1ns/1ps
module tb_control_io_decoder;
    import cio_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic pha_i = 0, phb_i = 0, touch_valid_i = 0, ack_o, touch_valid_o;
    logic [7:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic backlight_o, touch_locked_o, restart_o, measuring_o;
    logic continuous_o, disp_zero_o, load_zero_o;
    logic [4:0] work_num_o;
    logic [2:0] zone_o;
    cio_stat_s stat_o;
    cio_judge_s judge_o;
    logic [N_IN-1:0] want = '0, ctl_pins_i;
    int mismatches = 0, comparisons = 0, cycles = 0, i, k;
    logic [3:0] row_in [5] = '{4'h0, 4'h1, 4'h8, 4'h6, 4'hF};
    logic [4:0] row_out [5] = '{5'h01, 5'h02, 5'h09, 5'h07, 5'h10};
    always #10 clk_i = ~clk_i;
    cio_plc_model cio_plc_model_inst (.clk_i, .want_i(want),
        .pins_o(ctl_pins_i));
    cio_control_io_decoder #(.DEB_CYCLES(DEB_W'(4)),
        .WORK_CYCLES(WORK_W'(16))) cio_control_io_decoder_inst (.clk_i,
        .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .ctl_pins_i, .pha_i, .phb_i, .touch_valid_i,
        .touch_valid_o, .backlight_o, .touch_locked_o, .restart_o,
        .work_num_o, .zone_o, .measuring_o, .continuous_o, .disp_zero_o,
        .load_zero_o, .stat_o, .judge_o);
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic line(input int b, input logic v, input int w);
        @(posedge clk_i);
        want[b] <= v;
        repeat (w) @(posedge clk_i);
    endtask : line
    task automatic step(input logic a);
        @(posedge clk_i);
        if (a) pha_i <= ~pha_i;
        else phb_i <= ~phb_i;
        repeat (4) @(posedge clk_i);
    endtask : step
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // hang guard, well above the expected run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 6000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(work_num_o, 5'h01);
        chk({judge_o, stat_o}, '0);
        wb(0, ADR_ZONE_EN, '0);
        chk(rd, 32'h1F);
        wb(0, 8'h30, '0);
        chk(rd, '0);
        $display("test reset done");
        @(posedge clk_i);
        want[6:3] <= 4'h5;
        repeat (45) @(posedge clk_i);
        chk(work_num_o, 5'h01);
        wb(1, ADR_CTRL, 32'h0D);
        // table of work-line codes and the work numbers they select
        for (i = 0; i < 5; i++)
        begin
            @(posedge clk_i);
            want[6:3] <= row_in[i];
            repeat (45) @(posedge clk_i);
            chk(work_num_o, row_out[i]);
            wb(0, ADR_SELECT, '0);
            chk(rd[4:0], row_out[i]);
        end
        @(posedge clk_i);
        want[6:3] <= 4'h3;
        repeat (12) @(posedge clk_i);
        chk(work_num_o, 5'h10);
        $display("test work done");
        line(I_MEAS, 1, 20);
        chk(measuring_o, 1'b1);
        line(I_MEAS, 0, 20);
        chk({measuring_o, stat_o.complete}, 2'b01);
        wb(1, ADR_CTRL, 32'h1D);
        line(I_MEAS, 1, 20);
        chk(measuring_o, 1'b1);
        line(I_MEAS, 0, 20);
        chk(measuring_o, 1'b1);
        line(I_MEAS, 1, 20);
        chk(measuring_o, 1'b0);
        line(I_MEAS, 0, 20);
        wb(1, ADR_CTRL, 32'h13);
        line(I_MEAS, 1, 20);
        chk(measuring_o, 1'b0);
        $display("test measure done");
        wb(1, ADR_JUDGE, 32'hFFFF);
        line(I_MASK, 1, 20);
        chk(judge_o, '0);
        chk(stat_o, 5'h1F);
        line(I_MASK, 0, 20);
        chk(judge_o, 11'h7FF);
        line(I_CLEAR, 1, 20);
        chk({judge_o, continuous_o}, 12'h001);
        $display("test judge done");
        touch_valid_i <= 1'b1;
        line(I_TOUCH, 1, 0);
        line(I_BL, 1, 20);
        chk(backlight_o, 1'b1);
        chk({touch_locked_o, touch_valid_o}, 2'b10);
        line(I_TOUCH, 0, 20);
        chk({backlight_o, touch_valid_o}, 2'b11);
        $display("test panel done");
        // zones 0 and 2 enabled: stepping skips the others
        wb(1, ADR_ZONE_EN, 32'h05);
        line(I_ZONE, 1, 20);
        chk(zone_o, 3'h2);
        line(I_ZONE, 0, 20);
        line(I_ZONE, 1, 20);
        chk(zone_o, 3'h0);
        $display("test zone done");
        repeat (6) step(1);
        wb(0, ADR_DISP, '0);
        chk(rd, 32'h3);
        line(I_DZERO, 1, 20);
        wb(0, ADR_DISP, '0);
        chk(rd, '0);
        wb(1, ADR_CTRL, 32'h20);
        repeat (2) for (i = 0; i < 2; i++) step(i == 0);
        wb(0, ADR_DISP, '0);
        chk(rd, 32'h4);
        $display("test displacement done");
        line(I_RESTART, 1, 0);
        want[I_LZERO] <= 1'b1;
        for (k = 0; k < 30 && restart_o !== 1'b1; k++) @(posedge clk_i);
        chk({restart_o, load_zero_o, disp_zero_o}, 3'b110);
        wb(0, ADR_EVENTS, '0);
        chk(rd, 32'h7F);
        wb(1, ADR_EVENTS, 32'h7F);
        wb(0, ADR_EVENTS, '0);
        chk(rd, '0);
        wb(1, ADR_CMD, 32'h1);
        wb(0, ADR_STATUS, '0);
        chk(rd, 32'h3D9D);
        $display("test restart done");
        conclude();
    end
endmodule : tb_control_io_decoder
